// ==== shared/txhw_pkg.sv ====
// Package with register map, field positions, reset values and shared types for the TX/HW config bank.
package txhw_pkg;

    localparam int          ADDR_W            = 8;
    localparam logic [7:0]  OFS_TX_CONFIG     = 8'h70;
    localparam logic [7:0]  OFS_HW_CONFIG     = 8'h74;

    // Transmit configuration field positions.
    localparam int          TXC_STATUS_FLUSH  = 15;
    localparam int          TXC_DATA_FLUSH    = 14;
    localparam int          TXC_OVERRUN_ALLOW = 2;
    localparam int          TXC_TX_ENABLE     = 1;
    localparam int          TXC_HALT          = 0;

    // Hardware configuration field positions.
    localparam int          HWC_XOVER_STRAP   = 24;
    localparam int          HWC_MUST_BE_ONE   = 20;
    localparam int          HWC_ALLOC_LSB     = 16;
    localparam int          HWC_ALLOC_MSB     = 19;
    localparam int          HWC_BUS_WIDTH     = 2;
    localparam int          HWC_SR_TIMEOUT    = 1;
    localparam int          HWC_SOFT_RESET    = 0;

    // Reset values and sizing.
    localparam logic [3:0]  ALLOC_RESET       = 4'h5;
    localparam logic [3:0]  ALLOC_MIN         = 4'h2;
    localparam logic [3:0]  ALLOC_MAX         = 4'hE;
    localparam int          KB_BYTES          = 1024;
    localparam int          TOTAL_BYTES       = 16384;
    localparam int          TX_STATUS_BYTES   = 512;
    localparam int          SIZE_W            = 15;

    // Soft reset timeout: time in ns and derived cycles at 125 MHz.
    localparam int          CLK_PERIOD_NS     = 8;
    localparam int          SR_TIMEOUT_NS     = 10000;
    localparam int          SR_TIMEOUT_CYC    = SR_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int          SR_CNT_W          = 12;

    // Software-visible bus request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } txhw_req_type;

    // FIFO partition handed to the memory controller.
    typedef struct packed {
        logic [SIZE_W-1:0] tx_data_bytes;
        logic [SIZE_W-1:0] tx_status_bytes;
        logic [SIZE_W-1:0] rx_total_bytes;
    } txhw_alloc_type;

    typedef enum logic [1:0] {SR_IDLE, SR_WAIT, SR_PULSE} txhw_sr_type;

endpackage

// ==== hw/txhw_regs.sv ====
// TX configuration and hardware configuration register bank with soft reset sequencing.
//
// Notes on behaviour
// - Writing one to status flush zeroes TX status pointers; bit self-clears.
// - Writing one to data flush zeroes TX data pointers; bit self-clears.
// - Overrun allow zero pauses transmit on full status FIFO; one keeps sending.
// - Status FIFO full interrupt is independent of overrun allow.
// - Transmit enable set makes the transmitter run and send queued data.
// - Device clears transmit enable once halt requested and transmitter stopped.
// - Halt request finishes current frame, stops, then self-clears.
// - Writes to halt request are ignored while it reads one.
// - Read-only bit shows sampled crossover strap level; PHY may override.
// - Four-bit TX allocation in 1 kB steps, resets to 5, range 2..14.
// - TX status takes fixed 512 bytes; TX data gets the remainder.
// - RX FIFOs get 16 kB minus the TX allocation.
// - Read-only bus width bit: one for 32-bit, zero for 16-bit.
// - Soft reset without running PHY clocks never completes; timeout flag set.
// - Soft reset resets MAC and system registers except exempt bits; self-clears.
// - Soft reset clears latched transmit and receive error flags.
// - Writes take no effect until one read after reset or power saving.
`timescale 1ns/100ps

module txhw_regs #(
    parameter int SR_TIMEOUT = txhw_pkg::SR_TIMEOUT_CYC
) (
    input  wire logic                    REF_CLK,
    input  wire logic                    RST,
    input  wire txhw_pkg::txhw_req_type  BUS_REQ,
    output logic [31:0]                  BUS_RDATA,
    input  wire logic                    XOVER_STRAP,
    input  wire logic                    BUS_WIDTH_STRAP,
    input  wire logic                    PHY_CLKS_RUNNING,
    input  wire logic                    POWER_SAVE_EXIT,
    input  wire logic                    TX_STATUS_FULL,
    input  wire logic                    TX_FRAME_ACTIVE,
    input  wire logic                    TX_ERROR_EVENT,
    input  wire logic                    RX_ERROR_EVENT,
    output logic                         TX_RUN,
    output logic                         TX_STATUS_PTR_CLEAR,
    output logic                         TX_DATA_PTR_CLEAR,
    output logic                         TX_STATUS_FULL_IRQ,
    output logic                         MUST_BE_ONE_OK,
    output txhw_pkg::txhw_alloc_type     FIFO_ALLOC,
    output logic                         SOFT_RESET_PULSE,
    output logic                         TRANSMIT_ERROR_FLAG,
    output logic                         RECEIVE_ERROR_FLAG
);
    import txhw_pkg::*;

    logic                  tx_enable;
    logic                  overrun_allow;
    logic                  halt_request;
    logic                  must_be_one_bit;
    logic [3:0]            tx_fifo_allocation;
    logic                  soft_reset_timeout;
    logic                  soft_reset_request;
    logic                  read_seen;
    logic                  xover_meta;
    logic                  xover_sync;
    logic                  width_meta;
    logic                  width_sync;
    logic                  phy_meta;
    logic                  phy_sync;
    logic                  status_full_meta;
    logic                  status_full_sync;
    logic                  frame_meta;
    logic                  frame_sync;
    logic                  crossover_auto_strap;
    logic                  bus_width_strap;
    logic [1:0]            strap_wait;
    logic [SR_CNT_W-1:0]   sr_count;
    txhw_sr_type           sr_state;
    logic                  wr_tx;
    logic                  wr_hw;
    logic                  soft_clear;
    logic                  halted;
    logic [SIZE_W-1:0]     tx_total_bytes;

    // Writes are only honoured once software has done its first read.
    assign wr_tx          = BUS_REQ.wr && read_seen && BUS_REQ.addr == OFS_TX_CONFIG;
    assign wr_hw          = BUS_REQ.wr && read_seen && BUS_REQ.addr == OFS_HW_CONFIG;
    assign soft_clear     = sr_state == SR_PULSE;
    assign halted         = halt_request && !frame_sync;
    assign tx_total_bytes = SIZE_W'({tx_fifo_allocation, 10'h000});

    // Pins from outside the clock domain pass two flops before any logic sees them.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            xover_meta       <= 1'b0;
            xover_sync       <= 1'b0;
            width_meta       <= 1'b0;
            width_sync       <= 1'b0;
            phy_meta         <= 1'b0;
            phy_sync         <= 1'b0;
            status_full_meta <= 1'b0;
            status_full_sync <= 1'b0;
            frame_meta       <= 1'b0;
            frame_sync       <= 1'b0;
        end else begin
            xover_meta       <= XOVER_STRAP;
            xover_sync       <= xover_meta;
            width_meta       <= BUS_WIDTH_STRAP;
            width_sync       <= width_meta;
            phy_meta         <= PHY_CLKS_RUNNING;
            phy_sync         <= phy_meta;
            status_full_meta <= TX_STATUS_FULL;
            status_full_sync <= status_full_meta;
            frame_meta       <= TX_FRAME_ACTIVE;
            frame_sync       <= frame_meta;
        end
    end

    // Straps follow the synchronisers for three cycles after release, long enough for them
    // to fill, and are then frozen so that later pin wiggles are ignored.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            strap_wait           <= 2'h0;
            crossover_auto_strap <= 1'b0;
            bus_width_strap      <= 1'b0;
        end else if (strap_wait != 2'h3) begin
            strap_wait           <= strap_wait + 2'h1;
            crossover_auto_strap <= xover_sync;
            bus_width_strap      <= width_sync;
        end
    end

    // First-read gate; a return from power saving closes it again.
    always_ff @(posedge REF_CLK) begin
        if (RST || POWER_SAVE_EXIT) begin
            read_seen <= 1'b0;
        end else if (BUS_REQ.rd) begin
            read_seen <= 1'b1;
        end
    end

    // Transmit configuration register; soft reset returns it to defaults.
    always_ff @(posedge REF_CLK) begin
        if (RST || soft_clear) begin
            tx_enable     <= 1'b0;
            overrun_allow <= 1'b0;
            halt_request  <= 1'b0;
        end else begin
            if (wr_tx) begin
                overrun_allow <= BUS_REQ.wdata[TXC_OVERRUN_ALLOW];
                tx_enable     <= BUS_REQ.wdata[TXC_TX_ENABLE];
            end
            if (wr_tx && !halt_request) begin
                halt_request <= BUS_REQ.wdata[TXC_HALT];
            end else if (halted) begin
                halt_request <= 1'b0;
                tx_enable    <= 1'b0;
            end
        end
    end

    // Flush strobes are one-cycle pulses; the register bit itself never stores a one.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            TX_STATUS_PTR_CLEAR <= 1'b0;
            TX_DATA_PTR_CLEAR   <= 1'b0;
        end else begin
            TX_STATUS_PTR_CLEAR <= wr_tx && BUS_REQ.wdata[TXC_STATUS_FLUSH];
            TX_DATA_PTR_CLEAR   <= wr_tx && BUS_REQ.wdata[TXC_DATA_FLUSH];
        end
    end

    // Transmit gating: the run line drops the cycle after a halt request, while the current frame may still be active.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            TX_RUN             <= 1'b0;
            TX_STATUS_FULL_IRQ <= 1'b0;
        end else begin
            TX_RUN             <= tx_enable && !halt_request
                                  && (overrun_allow || !status_full_sync);
            TX_STATUS_FULL_IRQ <= status_full_sync;
        end
    end

    // Hardware configuration storage; the strap and width bits are read-only.
    always_ff @(posedge REF_CLK) begin
        if (RST || soft_clear) begin
            must_be_one_bit    <= 1'b0;
            tx_fifo_allocation <= ALLOC_RESET;
        end else if (wr_hw) begin
            must_be_one_bit    <= BUS_REQ.wdata[HWC_MUST_BE_ONE];
            tx_fifo_allocation <= BUS_REQ.wdata[HWC_ALLOC_MSB:HWC_ALLOC_LSB];
        end
    end

    // Soft reset sequencer: waits for live PHY clocks, else times out and gives up.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sr_state           <= SR_IDLE;
            sr_count           <= '0;
            soft_reset_request <= 1'b0;
            soft_reset_timeout <= 1'b0;
        end else begin
            unique case (sr_state)
                SR_IDLE: begin
                    if (wr_hw && BUS_REQ.wdata[HWC_SOFT_RESET]) begin
                        sr_state           <= SR_WAIT;
                        sr_count           <= '0;
                        soft_reset_request <= 1'b1;
                        soft_reset_timeout <= 1'b0;
                    end
                end
                SR_WAIT: begin
                    if (phy_sync) begin
                        sr_state <= SR_PULSE;
                    end else if (sr_count == SR_CNT_W'(SR_TIMEOUT - 1)) begin
                        sr_state           <= SR_IDLE;
                        soft_reset_request <= 1'b0;
                        soft_reset_timeout <= 1'b1;
                    end else begin
                        sr_count <= sr_count + 1'b1;
                    end
                end
                SR_PULSE: begin
                    sr_state           <= SR_IDLE;
                    soft_reset_request <= 1'b0;
                end
            endcase
        end
    end

    // Soft reset pulse to the rest of the MAC and system registers.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            SOFT_RESET_PULSE <= 1'b0;
        end else begin
            SOFT_RESET_PULSE <= soft_clear;
        end
    end

    // Latched error flags; an event in the clearing cycle still sets the flag.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            TRANSMIT_ERROR_FLAG <= 1'b0;
            RECEIVE_ERROR_FLAG  <= 1'b0;
        end else begin
            TRANSMIT_ERROR_FLAG <= TX_ERROR_EVENT || (TRANSMIT_ERROR_FLAG && !soft_clear);
            RECEIVE_ERROR_FLAG  <= RX_ERROR_EVENT || (RECEIVE_ERROR_FLAG && !soft_clear);
        end
    end

    // FIFO partition. Out-of-range settings are the host's fault and pass through unchanged.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            FIFO_ALLOC     <= '0;
            MUST_BE_ONE_OK <= 1'b0;
        end else begin
            FIFO_ALLOC.tx_status_bytes <= SIZE_W'(TX_STATUS_BYTES);
            FIFO_ALLOC.tx_data_bytes   <= tx_total_bytes - SIZE_W'(TX_STATUS_BYTES);
            FIFO_ALLOC.rx_total_bytes  <= SIZE_W'(TOTAL_BYTES) - tx_total_bytes;
            MUST_BE_ONE_OK             <= must_be_one_bit;
        end
    end

    // Read port: data one cycle after the strobe, zero elsewhere and on reserved bits.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            BUS_RDATA <= 32'h0000_0000;
        end else if (BUS_REQ.rd && BUS_REQ.addr == OFS_TX_CONFIG) begin
            BUS_RDATA <= '0;
            BUS_RDATA[TXC_OVERRUN_ALLOW] <= overrun_allow;
            BUS_RDATA[TXC_TX_ENABLE]     <= tx_enable;
            BUS_RDATA[TXC_HALT]          <= halt_request;
        end else if (BUS_REQ.rd && BUS_REQ.addr == OFS_HW_CONFIG) begin
            BUS_RDATA <= '0;
            BUS_RDATA[HWC_XOVER_STRAP]               <= crossover_auto_strap;
            BUS_RDATA[HWC_MUST_BE_ONE]               <= must_be_one_bit;
            BUS_RDATA[HWC_ALLOC_MSB:HWC_ALLOC_LSB]   <= tx_fifo_allocation;
            BUS_RDATA[HWC_BUS_WIDTH]                 <= bus_width_strap;
            BUS_RDATA[HWC_SR_TIMEOUT]                <= soft_reset_timeout;
            BUS_RDATA[HWC_SOFT_RESET]                <= soft_reset_request;
        end else begin
            BUS_RDATA <= 32'h0000_0000;
        end
    end

    // Checks on the behaviour above.
    chk_halt_write_ignored: assert property (@(posedge REF_CLK) disable iff (RST)
        halt_request && wr_tx && !halted && !soft_clear |=> halt_request)
        else $error("halt request changed by a write while set");
    chk_halt_clears_enable: assert property (@(posedge REF_CLK) disable iff (RST)
        halted && !soft_clear |=> !tx_enable && !halt_request)
        else $error("transmit enable not cleared after halt");
    chk_pause_on_full: assert property (@(posedge REF_CLK) disable iff (RST)
        status_full_sync && !overrun_allow |=> !TX_RUN)
        else $error("transmit ran with full status fifo");
    chk_status_flush_pulse: assert property (@(posedge REF_CLK) disable iff (RST)
        wr_tx && BUS_REQ.wdata[TXC_STATUS_FLUSH] |=> TX_STATUS_PTR_CLEAR ##1
        (!TX_STATUS_PTR_CLEAR || $past(wr_tx && BUS_REQ.wdata[TXC_STATUS_FLUSH])))
        else $error("status flush pulse wrong");
    chk_data_flush_pulse: assert property (@(posedge REF_CLK) disable iff (RST)
        wr_tx && BUS_REQ.wdata[TXC_DATA_FLUSH] |=> TX_DATA_PTR_CLEAR)
        else $error("data flush pulse missing");
    chk_full_irq_follows: assert property (@(posedge REF_CLK) disable iff (RST)
        status_full_sync |=> TX_STATUS_FULL_IRQ)
        else $error("full interrupt missing");
    chk_reset_timeout: assert property (@(posedge REF_CLK) disable iff (RST)
        sr_state == SR_WAIT && !phy_sync && sr_count == SR_CNT_W'(SR_TIMEOUT - 1)
        |=> soft_reset_timeout && !soft_reset_request)
        else $error("soft reset timeout not flagged");
    chk_reset_clears_errors: assert property (@(posedge REF_CLK) disable iff (RST)
        soft_clear && !TX_ERROR_EVENT |=> !TRANSMIT_ERROR_FLAG)
        else $error("soft reset left transmit error set");
    chk_write_gate: assert property (@(posedge REF_CLK) disable iff (RST)
        BUS_REQ.wr && !read_seen && !soft_clear && !halted |=> $stable(overrun_allow))
        else $error("write took effect before first read");
    chk_alloc_split: assert property (@(posedge REF_CLK) disable iff (RST)
        !$past(RST) |-> FIFO_ALLOC.rx_total_bytes + FIFO_ALLOC.tx_data_bytes
        + FIFO_ALLOC.tx_status_bytes == SIZE_W'(TOTAL_BYTES))
        else $error("fifo split does not add up");
    cov_halt: cover property (@(posedge REF_CLK) disable iff (RST) halted);
    cov_timeout: cover property (@(posedge REF_CLK) disable iff (RST) $rose(soft_reset_timeout));
    cov_soft_reset: cover property (@(posedge REF_CLK) disable iff (RST) SOFT_RESET_PULSE);
    cov_full_pause: cover property (@(posedge REF_CLK) disable iff (RST)
        tx_enable && status_full_sync && !overrun_allow);

endmodule

// ==== tb/txhw_mac_model.sv ====
// Behavioural transmit engine that keeps one frame in flight for a fixed time.
`timescale 1ns/100ps

module txhw_mac_model #(
    parameter int FRAME_LEN = 40
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic tx_run,
    input  wire logic start,
    output logic      frame_active
);
    int cnt;

    // A frame starts only while running and then ends on its own, so a halt must wait for it.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 0;
        end else if (start && tx_run) begin
            cnt <= FRAME_LEN;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    // The frame is active while the countdown has not run out.
    assign frame_active = (cnt > 0);
endmodule

// ==== tb/txhw_regs_test.sv ====
// Self-checking bench for the transmit and hardware configuration register bank.
`timescale 1ns/100ps

module txhw_regs_test;
    import txhw_pkg::*;

    localparam int          SRT     = 16;
    localparam logic [31:0] HW_DFLT = 32'h0105_0000;
    logic           ref_clk = 1'b0;
    logic           rst = 1'b1;
    txhw_req_type   req = '0;
    logic           phy_run = 1'b0, ps_exit = 1'b0, st_full = 1'b0, fr_start = 1'b0;
    logic           tx_err = 1'b0, rx_err = 1'b0;
    logic           xo_pin = 1'b1, bw_pin = 1'b0;
    logic           fr_act, tx_run, st_clr, dt_clr, irq, mbo_ok, sr_pulse, transmit_error_flag, receive_error_flag;
    logic [31:0]    rdata, rv;
    txhw_alloc_type alloc;
    int             miscompares = 0, cmp_count = 0, cycles = 0;

    // Free-running system clock at 125 MHz.
    always #4 ref_clk = ~ref_clk;

    txhw_regs #(.SR_TIMEOUT(SRT)) i_txhw_regs (
        .REF_CLK(ref_clk), .RST(rst), .BUS_REQ(req), .BUS_RDATA(rdata),
        .XOVER_STRAP(xo_pin), .BUS_WIDTH_STRAP(bw_pin), .PHY_CLKS_RUNNING(phy_run),
        .POWER_SAVE_EXIT(ps_exit), .TX_STATUS_FULL(st_full), .TX_FRAME_ACTIVE(fr_act),
        .TX_ERROR_EVENT(tx_err), .RX_ERROR_EVENT(rx_err), .TX_RUN(tx_run),
        .TX_STATUS_PTR_CLEAR(st_clr), .TX_DATA_PTR_CLEAR(dt_clr), .TX_STATUS_FULL_IRQ(irq),
        .MUST_BE_ONE_OK(mbo_ok), .FIFO_ALLOC(alloc), .SOFT_RESET_PULSE(sr_pulse),
        .TRANSMIT_ERROR_FLAG(transmit_error_flag), .RECEIVE_ERROR_FLAG(receive_error_flag));

    txhw_mac_model i_txhw_mac_model (.clk(ref_clk), .rst(rst), .tx_run(tx_run),
        .start(fr_start), .frame_active(fr_act));

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Waits n edges and then lets that edge's updates settle before sampling.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        reg_rd(a, d);
        chk(what, exp, d);
    endtask

    task automatic chk_alloc(input int n);
        chk("alloc_tx_data", 32'(n * 1024 - 512), 32'(alloc.tx_data_bytes));
        chk("alloc_tx_status", 32'd512, 32'(alloc.tx_status_bytes));
        chk("alloc_rx", 32'(16384 - n * 1024), 32'(alloc.rx_total_bytes));
    endtask

    // Cuts a hang short well beyond the few hundred cycles the tests need.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    // Main sequence of register accesses and port checks.
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        tick(4);
        reg_wr(OFS_TX_CONFIG, 32'h4);
        chk_rd(OFS_TX_CONFIG, 32'h0, "write_before_read");
        reg_wr(OFS_TX_CONFIG, 32'hFFFF_3FFC);
        chk_rd(OFS_TX_CONFIG, 32'h4, "tx_reserved");
        chk_rd(OFS_HW_CONFIG, HW_DFLT, "hw_reset");
        chk_alloc(5);
        chk("must_be_one_ok", 32'h0, 32'(mbo_ok));
        reg_wr(OFS_HW_CONFIG, 32'hFEF6_FFF8);
        chk_rd(OFS_HW_CONFIG, 32'h0116_0000, "hw_reserved");
        reg_wr(8'h78, 32'hFFFF_FFFF);
        chk_rd(8'h78, 32'h0, "unmapped");
        // Every legal allocation from the smallest to the largest.
        for (int n = 2; n <= 14; n++) begin
            reg_wr(OFS_HW_CONFIG, {11'h0, 1'b1, 4'(n), 16'h0});
            tick(2);
            chk_alloc(n);
            chk_rd(OFS_HW_CONFIG, {11'h0, 1'b1, 4'(n), 16'h0} | 32'h0100_0000, "alloc");
        end
        chk("must_be_one_ok", 32'h1, 32'(mbo_ok));
        // Status flush then data flush, each a single pulse that leaves the bit clear.
        for (int i = 0; i < 2; i++) begin
            reg_wr(OFS_TX_CONFIG, i ? 32'h4004 : 32'h8004);
            #1 chk("flush_pulse", i ? 32'h1 : 32'h2, {30'h0, st_clr, dt_clr});
            tick(1);
            chk("flush_end", 32'h0, {30'h0, st_clr, dt_clr});
            chk_rd(OFS_TX_CONFIG, 32'h4, "flush_clear");
        end
        reg_wr(OFS_TX_CONFIG, 32'h2);
        tick(3);
        chk("tx_run_on", 32'h1, 32'(tx_run));
        @(posedge ref_clk) st_full <= 1'b1;
        tick(5);
        chk("pause_on_full", 32'h0, 32'(tx_run));
        chk("full_irq", 32'h1, 32'(irq));
        reg_wr(OFS_TX_CONFIG, 32'h6);
        tick(3);
        chk("overrun_run", 32'h1, 32'(tx_run));
        chk("full_irq_allow", 32'h1, 32'(irq));
        @(posedge ref_clk) st_full <= 1'b0;
        tick(5);
        chk("full_irq_off", 32'h0, 32'(irq));
        // Halt during a frame: the halt bit holds until the frame ends.
        @(posedge ref_clk) fr_start <= 1'b1;
        @(posedge ref_clk) fr_start <= 1'b0;
        tick(4);
        reg_wr(OFS_TX_CONFIG, 32'h3);
        tick(2);
        chk("halt_stops_run", 32'h0, 32'(tx_run));
        reg_wr(OFS_TX_CONFIG, 32'h2);
        chk_rd(OFS_TX_CONFIG, 32'h3, "halt_pending");
        for (int k = 0; k < 60 && fr_act; k++) tick(1);
        tick(6);
        chk_rd(OFS_TX_CONFIG, 32'h0, "halt_done");
        // Latched errors, then a soft reset that times out and one that completes.
        @(posedge ref_clk) {tx_err, rx_err} <= 2'b11;
        @(posedge ref_clk) {tx_err, rx_err} <= 2'b00;
        tick(2);
        chk("error_flags", 32'h3, {30'h0, transmit_error_flag, receive_error_flag});
        reg_wr(OFS_TX_CONFIG, 32'h4);
        reg_wr(OFS_HW_CONFIG, 32'h001E_0001);
        reg_rd(OFS_HW_CONFIG, rv);
        chk("sr_pending", 32'h1, rv & 32'h1);
        tick(SRT + 4);
        reg_rd(OFS_HW_CONFIG, rv);
        chk("sr_timeout", 32'h1, 32'(rv[1]));
        chk("flags_kept", 32'h3, {30'h0, transmit_error_flag, receive_error_flag});
        @(posedge ref_clk) phy_run <= 1'b1;
        tick(4);
        reg_wr(OFS_HW_CONFIG, 32'h001E_0001);
        for (int k = 0; k < 50 && sr_pulse !== 1'b1; k++) tick(1);
        chk("sr_pulse", 32'h1, 32'(sr_pulse));
        tick(1);
        chk("flags_cleared", 32'h0, {30'h0, transmit_error_flag, receive_error_flag});
        reg_rd(OFS_HW_CONFIG, rv);
        chk("hw_after_sr", HW_DFLT, rv & 32'hFFFF_FFFD);
        chk_rd(OFS_TX_CONFIG, 32'h0, "tx_after_sr");
        chk_alloc(5);
        // Leaving power saving closes the write path until a read is made.
        @(posedge ref_clk) ps_exit <= 1'b1;
        @(posedge ref_clk) ps_exit <= 1'b0;
        reg_wr(OFS_TX_CONFIG, 32'h4);
        chk_rd(OFS_TX_CONFIG, 32'h0, "ps_gate");
        reg_wr(OFS_TX_CONFIG, 32'h4);
        chk_rd(OFS_TX_CONFIG, 32'h4, "ps_reopen");
        // Strap pins move after capture; only a fresh reset samples them again.
        @(posedge ref_clk) {xo_pin, bw_pin} <= 2'b01;
        tick(4);
        chk_rd(OFS_HW_CONFIG, HW_DFLT, "strap_held");
        @(posedge ref_clk) rst <= 1'b1;
        tick(3);
        @(posedge ref_clk) rst <= 1'b0;
        tick(4);
        chk_rd(OFS_HW_CONFIG, 32'h0005_0004, "strap_resample");
        chk_alloc(5);
        give_verdict();
    end
endmodule
